// *** rtl/fpsl_pkg.sv ***
// Constants for the flash program/suspend/lock host controller.
// Assumes a 100 MHz system clock and a byte-wide asynchronous flash.
package fpsl_pkg;
  // ****************************************
  // APB register map (byte offsets)
  // ****************************************
  localparam logic [7:0] REG_CTRL = 8'h00; // Operation launch and pin control
  localparam logic [7:0] REG_ADDR = 8'h04; // Flash target address
  localparam logic [7:0] REG_WDATA = 8'h08; // Byte to program
  localparam logic [7:0] REG_STAT = 8'h0C; // Controller state and last status
  localparam logic [7:0] REG_RDATA = 8'h10; // Last array byte read from flash
  // CTRL fields
  localparam int CTRL_OP_LSB = 0; // Operation code, 3 bits
  localparam int CTRL_GO = 3; // Write 1 to launch
  localparam int CTRL_NOWAIT = 4; // Skip the ready poll
  localparam int CTRL_HV = 5; // Drive the high-voltage level on reset pin
  localparam int CTRL_RST = 6; // Hold the flash in reset/power-down
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000; // Reset value
  // STAT fields
  localparam int STAT_BUSY = 0; // Sequence running
  localparam int STAT_REFUSED = 1; // Sticky, write 1 to clear
  localparam int STAT_ESUSP = 2; // Erase suspended
  localparam int STAT_PSUSP = 3; // Program suspended
  localparam int STAT_PEND = 4; // Program launched in erase suspend
  localparam int STAT_OPERR = 5; // Sticky, write 1 to clear
  localparam int STAT_SR_LSB = 8; // Last flash status byte
  // ****************************************
  // Operations
  // ****************************************
  localparam logic [2:0] OP_READ_ARRAY = 3'h0;
  localparam logic [2:0] OP_READ_STATUS = 3'h1;
  localparam logic [2:0] OP_CLEAR = 3'h2;
  localparam logic [2:0] OP_PROGRAM = 3'h3;
  localparam logic [2:0] OP_SUSPEND = 3'h4;
  localparam logic [2:0] OP_RESUME = 3'h5;
  localparam logic [2:0] OP_LOCK_BLOCK = 3'h6;
  localparam logic [2:0] OP_LOCK_MASTER = 3'h7;
  // Flash command bytes
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR = 8'h50;
  localparam logic [7:0] CMD_PROGRAM = 8'h40;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESUME = 8'hD0;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_LOCK_BLOCK = 8'h01;
  localparam logic [7:0] CMD_LOCK_MASTER = 8'hF1;
  // Flash status byte bits
  localparam int SR_READY = 7;
  localparam int SR_ESUSP = 6;
  localparam int SR_EERR = 5;
  localparam int SR_PERR = 4;
  localparam int SR_VLOW = 3;
  localparam int SR_PSUSP = 2;
  localparam int SR_PROT = 1;
  // ****************************************
  // Bus timing
  // ****************************************
  localparam int CLK_NS = 10; // Clock period
  localparam int T_ACC_NS = 130; // Read access time
  localparam int T_WP_NS = 50; // Write-enable low pulse
  localparam int T_WH_NS = 20; // Hold after write-enable rises
  localparam int T_REC_NS = 20; // Chip-enable high between reads
  localparam logic [7:0] ACC_CYC = 8'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] WP_CYC = 8'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] WH_CYC = 8'((T_WH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] REC_CYC = 8'((T_REC_NS + CLK_NS - 1) / CLK_NS);
  // Bus engine states, Gray along write then read
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WSET = 3'b001,
    ST_WLOW = 3'b011,
    ST_WHIGH = 3'b010,
    ST_RLOW = 3'b110,
    ST_RHIGH = 3'b111
  } fpsl_state_t;
  // ****************************************
  // Helper functions
  // ****************************************
  // Whether an operation needs two bus writes
  function automatic logic nwr2(input logic [2:0] op);
    nwr2 = (op == OP_PROGRAM) || (op == OP_LOCK_BLOCK) || (op == OP_LOCK_MASTER);
  endfunction

  // Byte for a given write step
  function automatic logic [7:0] wr_byte(input logic [2:0] op, input logic step,
                                         input logic clr, input logic [7:0] wd);
    wr_byte = CMD_CLEAR;
    if (!clr) begin
      case (op)
        OP_READ_ARRAY: wr_byte = CMD_READ_ARRAY;
        OP_READ_STATUS: wr_byte = CMD_READ_STATUS;
        OP_PROGRAM: wr_byte = step ? wd : CMD_PROGRAM;
        OP_SUSPEND: wr_byte = CMD_SUSPEND;
        OP_RESUME: wr_byte = CMD_RESUME;
        OP_LOCK_BLOCK: wr_byte = step ? CMD_LOCK_BLOCK : CMD_LOCK_SETUP;
        OP_LOCK_MASTER: wr_byte = step ? CMD_LOCK_MASTER : CMD_LOCK_SETUP;
        default: wr_byte = CMD_CLEAR;
      endcase
    end
  endfunction

  // Whether an operation may be launched in the current suspend state
  function automatic logic allowed(input logic [2:0] op, input logic es,
                                   input logic ps, input logic pend);
    allowed = 1'b1;
    if (op == OP_RESUME && pend && !ps) begin
      allowed = 1'b0;
    end else if (ps) begin
      allowed = (op == OP_READ_ARRAY) || (op == OP_READ_STATUS) || (op == OP_RESUME);
    end else if (es) begin
      allowed = (op != OP_CLEAR) && (op != OP_LOCK_BLOCK) && (op != OP_LOCK_MASTER);
    end
  endfunction
endpackage

// *** rtl/fpsl_host.sv ***
// Host controller that drives a byte-wide asynchronous flash through its pins.
// Assumes APB from software, a 100 MHz clock, and flash pins synchronous to it.
`timescale 1ns/1ps
module fpsl_host
  import fpsl_pkg::*;
#(
  parameter int ADDR_W = 20 // Flash address width
) (
  input wire logic ref_clk, // System clock
  input wire logic rst, // Async reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  output logic [ADDR_W-1:0] flash_addr, // Flash address
  output logic [7:0] flash_dq_o, // Flash data out
  output logic flash_dq_oe, // Flash data drive enable
  input wire logic [7:0] flash_dq_i, // Flash data in
  output logic flash_ce_n, // Flash chip enable
  output logic flash_we_n, // Flash write enable
  output logic flash_oe_n, // Flash output enable
  output logic flash_rp_n, // Flash reset/power-down, low resets
  output logic flash_rp_hv // Raise reset pin to high voltage
);
  // ****************************************
  // State
  // ****************************************
  fpsl_state_t state_reg, state_next; // Bus engine state
  logic [7:0] cnt_reg, cnt_next; // Phase cycle counter
  logic [2:0] op_reg, op_next; // Running operation
  logic step_reg, step_next; // Which write of the pair
  logic clr_reg, clr_next; // Doing the automatic clear write
  logic nowait_reg, nowait_next; // Skip poll for this run
  logic hv_reg, hv_next; // High-voltage request
  logic rst_pin_reg, rst_pin_next; // Flash held in reset
  logic [ADDR_W-1:0] addr_reg, addr_next; // Target address
  logic [7:0] wdata_reg, wdata_next; // Program data
  logic [7:0] rdata_reg, rdata_next; // Last array byte read
  logic [7:0] sr_reg, sr_next; // Last status byte polled
  logic [7:0] rd_byte_reg, rd_byte_next; // Byte sampled this read
  logic refused_reg, refused_next; // Sticky launch refusal
  logic operr_reg, operr_next; // Sticky flash error seen
  logic esusp_reg, esusp_next; // Erase believed suspended
  logic psusp_reg, psusp_next; // Program believed suspended
  logic pend_reg, pend_next; // Program in erase suspend unfinished
  logic [31:0] prdata_reg, prdata_next; // Registered read data
  logic ce_n_reg, ce_n_next, we_n_reg, we_n_next, oe_n_reg, oe_n_next; // Strobes
  logic dq_oe_reg, dq_oe_next; // Data drive
  logic [7:0] dq_o_reg, dq_o_next; // Data out
  logic apb_wr, apb_setup, mapped; // Bus decode
  logic polling, sr_bad; // Poll helpers
  assign apb_wr = psel && penable && pwrite;
  assign apb_setup = psel && !penable;
  assign mapped = (paddr == REG_CTRL) || (paddr == REG_ADDR) || (paddr == REG_WDATA) ||
                  (paddr == REG_STAT) || (paddr == REG_RDATA);
  // Zero-wait slave; a full answer lands in the access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  // Reads that loop until ready
  assign polling = !nowait_reg && (op_reg != OP_READ_ARRAY) && (op_reg != OP_READ_STATUS);
  assign sr_bad = rd_byte_reg[SR_EERR] | rd_byte_reg[SR_PERR] | rd_byte_reg[SR_VLOW] |
                  rd_byte_reg[SR_PROT];
  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    op_next = op_reg;
    step_next = step_reg;
    clr_next = clr_reg;
    nowait_next = nowait_reg;
    hv_next = hv_reg;
    rst_pin_next = rst_pin_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    sr_next = sr_reg;
    rd_byte_next = rd_byte_reg;
    refused_next = refused_reg;
    operr_next = operr_reg;
    esusp_next = esusp_reg;
    psusp_next = psusp_reg;
    pend_next = pend_reg;
    prdata_next = prdata_reg;
    // Register reads captured in setup so data is steady in access
    if (apb_setup && !pwrite) begin
      case (paddr)
        REG_CTRL: prdata_next = {25'h000_0000, rst_pin_reg, hv_reg, nowait_reg, 1'b0, op_reg};
        REG_ADDR: prdata_next = 32'(addr_reg);
        REG_WDATA: prdata_next = {24'h00_0000, wdata_reg};
        REG_STAT: prdata_next = {16'h0000, sr_reg, 2'b00, operr_reg, pend_reg, psusp_reg,
                                 esusp_reg, refused_reg, state_reg != ST_IDLE};
        REG_RDATA: prdata_next = {24'h00_0000, rdata_reg};
        default: prdata_next = 32'h0000_0000; // Unmapped reads as zero
      endcase
    end
    // Software writes; clears come first so a set later wins
    if (apb_wr) begin
      case (paddr)
        REG_ADDR: if (state_reg == ST_IDLE) addr_next = pwdata[ADDR_W-1:0]; // Frozen while busy
        REG_WDATA: if (state_reg == ST_IDLE) wdata_next = pwdata[7:0]; // Frozen while busy
        REG_STAT: begin
          if (pwdata[STAT_REFUSED]) refused_next = 1'b0;
          if (pwdata[STAT_OPERR]) operr_next = 1'b0;
        end
        REG_CTRL: begin
          hv_next = pwdata[CTRL_HV];
          rst_pin_next = pwdata[CTRL_RST];
          if (pwdata[CTRL_GO]) begin
            // Launch only from idle and only commands the flash honours now
            if (state_reg != ST_IDLE || rst_pin_reg ||
                !allowed(pwdata[CTRL_OP_LSB +: 3], esusp_reg, psusp_reg, pend_reg)) begin
              refused_next = 1'b1;
            end else begin
              op_next = pwdata[CTRL_OP_LSB +: 3];
              nowait_next = pwdata[CTRL_NOWAIT];
              step_next = 1'b0;
              clr_next = 1'b0;
              cnt_next = 8'h00;
              state_next = ST_WSET;
              if (pwdata[CTRL_OP_LSB +: 3] == OP_PROGRAM && esusp_reg) pend_next = 1'b1;
              if (pwdata[CTRL_OP_LSB +: 3] == OP_RESUME) begin
                if (psusp_reg) psusp_next = 1'b0;
                else esusp_next = 1'b0;
              end
            end
          end
        end
        default: ;
      endcase
    end
    // Bus engine
    case (state_reg)
      ST_IDLE: cnt_next = 8'h00;
      ST_WSET: begin // Address and data settle before the strobe
        state_next = ST_WLOW;
        cnt_next = 8'h00;
      end
      ST_WLOW: begin
        cnt_next = cnt_reg + 8'h01;
        if (cnt_reg == WP_CYC - 8'h01) begin
          state_next = ST_WHIGH; // Rising strobe latches address and data
          cnt_next = 8'h00;
        end
      end
      ST_WHIGH: begin
        cnt_next = cnt_reg + 8'h01;
        if (cnt_reg == WH_CYC - 8'h01) begin
          cnt_next = 8'h00;
          if (!clr_reg && !step_reg && nwr2(op_reg)) begin
            step_next = 1'b1; // Second half of the pair
            state_next = ST_WSET;
          end else if (clr_reg || op_reg == OP_CLEAR || op_reg == OP_RESUME ||
                       (nowait_reg && op_reg != OP_READ_ARRAY && op_reg != OP_READ_STATUS)) begin
            state_next = ST_IDLE; // Last write, no read back
          end else begin
            state_next = ST_RLOW;
          end
        end
      end
      ST_RLOW: begin
        cnt_next = cnt_reg + 8'h01;
        if (cnt_reg == ACC_CYC - 8'h01) begin
          rd_byte_next = flash_dq_i;
          state_next = ST_RHIGH;
          cnt_next = 8'h00;
        end
      end
      ST_RHIGH: begin // Strobes high so the status latch refreshes
        cnt_next = cnt_reg + 8'h01;
        if (cnt_reg == REC_CYC - 8'h01) begin
          cnt_next = 8'h00;
          state_next = ST_IDLE;
          if (op_reg == OP_READ_ARRAY) begin
            rdata_next = rd_byte_reg;
          end else if (polling && !rd_byte_reg[SR_READY]) begin
            state_next = ST_RLOW; // Still busy, poll again
          end else begin
            sr_next = rd_byte_reg;
            if (rd_byte_reg[SR_READY] && !rd_byte_reg[SR_PSUSP] && !psusp_reg) begin
              pend_next = 1'b0; // Program under erase suspend has ended
            end
            if (op_reg == OP_SUSPEND) begin
              psusp_next = rd_byte_reg[SR_PSUSP];
              if (!rd_byte_reg[SR_PSUSP]) esusp_next = rd_byte_reg[SR_ESUSP];
            end
            if (polling && sr_bad) begin
              operr_next = 1'b1;
              clr_next = 1'b1; // Flash error: clear its status
              state_next = ST_WSET;
            end
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
    // Pin values follow the state being entered
    ce_n_next = (state_next == ST_IDLE) || (state_next == ST_RHIGH);
    we_n_next = state_next != ST_WLOW;
    oe_n_next = state_next != ST_RLOW;
    dq_oe_next = (state_next == ST_WSET) || (state_next == ST_WLOW) || (state_next == ST_WHIGH);
    dq_o_next = dq_o_reg;
    if (state_next == ST_WSET) begin
      dq_o_next = wr_byte(op_next, step_next, clr_next, wdata_next);
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 8'h00;
      op_reg <= OP_READ_ARRAY;
      step_reg <= 1'b0;
      clr_reg <= 1'b0;
      nowait_reg <= CTRL_RESET[CTRL_NOWAIT];
      hv_reg <= CTRL_RESET[CTRL_HV];
      rst_pin_reg <= CTRL_RESET[CTRL_RST];
      addr_reg <= '0;
      wdata_reg <= 8'h00;
      rdata_reg <= 8'h00;
      sr_reg <= 8'h00;
      rd_byte_reg <= 8'h00;
      refused_reg <= 1'b0;
      operr_reg <= 1'b0;
      esusp_reg <= 1'b0;
      psusp_reg <= 1'b0;
      pend_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      ce_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      dq_oe_reg <= 1'b0;
      dq_o_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      op_reg <= op_next;
      step_reg <= step_next;
      clr_reg <= clr_next;
      nowait_reg <= nowait_next;
      hv_reg <= hv_next;
      rst_pin_reg <= rst_pin_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      sr_reg <= sr_next;
      rd_byte_reg <= rd_byte_next;
      refused_reg <= refused_next;
      operr_reg <= operr_next;
      esusp_reg <= esusp_next;
      psusp_reg <= psusp_next;
      pend_reg <= pend_next;
      prdata_reg <= prdata_next;
      ce_n_reg <= ce_n_next;
      we_n_reg <= we_n_next;
      oe_n_reg <= oe_n_next;
      dq_oe_reg <= dq_oe_next;
      dq_o_reg <= dq_o_next;
    end
  end

  assign prdata = prdata_reg;
  assign flash_addr = addr_reg;
  assign flash_dq_o = dq_o_reg;
  assign flash_dq_oe = dq_oe_reg;
  assign flash_ce_n = ce_n_reg;
  assign flash_we_n = we_n_reg;
  assign flash_oe_n = oe_n_reg;
  assign flash_rp_n = !rst_pin_reg;
  assign flash_rp_hv = hv_reg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_WE_DATA: assert property ($rose(flash_we_n) |-> flash_dq_oe && !flash_ce_n)
    else $error("write strobe rose without data driven");
  AST_PROG_SETUP: assert property ($fell(flash_we_n) && op_reg == OP_PROGRAM && !step_reg &&
    !clr_reg |-> flash_dq_o == CMD_PROGRAM ##1 flash_dq_o == CMD_PROGRAM)
    else $error("program setup byte wrong");
  AST_CLR_AFTER_ERR: assert property (state_reg == ST_RHIGH && cnt_reg == REC_CYC - 8'h01 &&
    polling && rd_byte_reg[SR_READY] && sr_bad && !clr_reg |=> flash_dq_o == CMD_CLEAR &&
    state_reg == ST_WSET)
    else $error("flash error not followed by clear");
  AST_RESUME_BLOCK: assert property ($fell(flash_we_n) && flash_dq_o == CMD_RESUME &&
    op_reg == OP_RESUME && !esusp_reg |-> !pend_reg)
    else $error("resume issued while program pending");
  AST_LOCK_CONFIRM: assert property ($rose(flash_we_n) && step_reg && !clr_reg &&
    op_reg == OP_LOCK_BLOCK |-> flash_dq_o == CMD_LOCK_BLOCK && $stable(flash_addr))
    else $error("block lock confirm wrong");
  AST_POLL_DONE: assert property ($fell(state_reg != ST_IDLE) && !nowait_reg && !clr_reg &&
    (op_reg == OP_LOCK_BLOCK || op_reg == OP_LOCK_MASTER) |-> sr_reg[SR_READY])
    else $error("lock finished without ready status");
  AST_CLEAR_SINGLE: assert property ($rose(flash_we_n) && (clr_reg || op_reg == OP_CLEAR) |->
    flash_dq_o == CMD_CLEAR && flash_oe_n throughout ##[1:16] state_reg == ST_IDLE)
    else $error("clear status not a single write");
  AST_RESUME_ONE: assert property ($rose(flash_we_n) && op_reg == OP_RESUME |->
    flash_dq_o == CMD_RESUME ##[1:16] state_reg == ST_IDLE)
    else $error("resume not a single write");
endmodule // fpsl_host

// *** tb/fpsl_flash_model.sv ***
// Behavioural byte-wide flash on the far side of the host controller.
// Assumes active-low strobes; a write latches as write-enable rises.
`timescale 1ns/1ps
module fpsl_flash_model #(
  parameter int BUSY = 3000 // Job time in ns
) (
  input wire logic [19:0] a, // Address
  input wire logic [7:0] d, // Resolved data bus
  output logic [7:0] q, // Read data
  input wire logic ce_n, // Chip enable
  input wire logic we_n, // Write enable
  input wire logic oe_n, // Output enable
  input wire logic hv, // Reset pin at high voltage
  input wire logic low // Supply at lockout
);
  logic [7:0] mem [int]; // Unwritten bytes read as erased
  logic [15:0] lck = 16'h0000; // Block locks, 64 KB blocks
  logic mst = 0, sm = 0, es = 0, ps = 0; // Master lock, status mode, suspends
  logic [7:0] err = 8'h00, stp = 8'h00, st, lat = 8'h00, cmd = 8'h00; // Flags, setup, latch
  time pe = 0, ee = 0, pl = 0, el = 0; // Job ends and time left

  // Ready only while no unsuspended job runs
  function automatic logic [7:0] sr();
    return {(ps || $time >= pe) && (es || $time >= ee), es, err[5:3], ps, err[1:0]};
  endfunction

  // Command decoder; errors abort with memory untouched
  always @(posedge we_n) if (!ce_n) begin
    cmd = d;
    st = stp;
    stp = 0;
    sm = 1;
    if (st == 8'h60) begin
      if (d == 8'h01 && mst && !hv || d == 8'hF1 && !hv) err |= 8'h12;
      else if (d == 8'h01) lck[a[19:16]] = 1;
      else if (d == 8'hF1) mst = 1;
      else err |= 8'h30;
    end else if (st != 0) begin
      if (low) err |= 8'h18;
      else if (lck[a[19:16]] && !hv) err |= 8'h12;
      else begin
        mem[a] = (mem.exists(a) ? mem[a] : 8'hFF) & d;
        pe = $time + BUSY;
      end
    end else case (d)
      8'hFF: sm = 0;
      8'h50: if (!es && !ps) err = 0;
      8'h40, 8'h10, 8'h60: if (!ps && !(es && d == 8'h60)) stp = d;
      8'hB0: if ($time < pe) begin
        pl = pe - $time;
        pe = 0;
        ps = 1;
      end else if ($time < ee) begin
        el = ee - $time;
        ee = 0;
        es = 1;
      end
      8'hD0: if (ps) begin
        pe = $time + pl;
        ps = 0;
      end else if (es && $time >= pe) begin
        ee = $time + el;
        es = 0;
      end
      default: ;
    endcase
  end

  // Latch a byte once both enables are low
  always @(negedge oe_n or negedge ce_n) begin
    #1;
    if (!ce_n && !oe_n) lat = sm ? sr() : (mem.exists(a) ? mem[a] : 8'hFF);
  end
  // A released bus shows the inverse, never a stale copy
  assign q = (!ce_n && !oe_n) ? lat : ~lat;
endmodule // fpsl_flash_model

// *** tb/testbench.sv ***
// Self-checking bench: host controller driving the flash model.
// Assumes fpsl_pkg, fpsl_host and fpsl_flash_model compiled first.
`timescale 1ns/1ps
module testbench import fpsl_pkg::*; ;
  logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, low = 0, err;
  logic [7:0] paddr = 8'h00, dat, exp_b, dq_o, fq, dq_i;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, e;
  logic pready, pslverr, oe, ce_n, we_n, oe_n, rp_n, hv;
  logic [19:0] fa;
  int n_fail = 0, n_compared = 0, cyc = 0, seed = 94124;
  // Address, high voltage, op, expected status
  logic [31:0] tbl [7] = '{32'h1000_5680, 32'h1000_5392, 32'h1000_5B80, 32'h0000_0792,
    32'h0000_0F80, 32'h2000_0692, 32'h2000_0E80};
  assign dq_i = oe ? dq_o : fq; // Bus level from both drivers
  fpsl_host dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flash_addr(fa), .flash_dq_o(dq_o), .flash_dq_oe(oe),
    .flash_dq_i(dq_i), .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n),
    .flash_rp_n(rp_n), .flash_rp_hv(hv));
  fpsl_flash_model flash (.a(fa), .d(dq_i), .q(fq), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
    .hv(hv), .low(low));
  initial forever #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    n_compared++;
    if (g !== x) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask
  // One APB transfer; holds everything until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d = 32'h0000_0000);
    @(posedge ref_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Launch an operation and poll until the controller is idle
  task automatic go(input logic [2:0] c, input logic [19:0] ad, input logic [31:0] f);
    apb(1, REG_ADDR, 32'(ad));
    apb(1, REG_CTRL, f | 32'h0000_0008 | 32'(c));
    do apb(0, REG_STAT); while (rd[STAT_BUSY] !== 1'b0);
  endtask
  task automatic waitr();
    do go(OP_READ_STATUS, 20'h0_0000, 0); while (rd[15] !== 1'b1);
  endtask
  task automatic rdarr(input logic [19:0] ad, input logic [7:0] x);
    go(OP_READ_ARRAY, ad, 0);
    apb(0, REG_RDATA);
    chk("rdata", x, rd[7:0]);
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 0;
    apb(0, REG_STAT);
    chk("stat", 8'h00, rd[7:0]);
    apb(0, 8'h20);
    chk("slverr", 8'h01, 8'(err));
    // Flash held in reset: pin low and every launch refused
    apb(1, REG_CTRL, 32'h0000_0040);
    go(OP_READ_STATUS, 20'h0_0000, 32'h0000_0040);
    chk("rp_n", 8'h00, 8'(rp_n));
    chk("refused", 8'h01, 8'(rd[STAT_REFUSED]));
    apb(1, REG_STAT, 32'h0000_0022);
    apb(1, REG_CTRL, 32'h0000_0000);
    // Second program may only clear further bits
    dat = 8'($random(seed));
    exp_b = dat;
    apb(1, REG_WDATA, 32'(dat));
    go(OP_PROGRAM, 20'h0_1234, 0);
    chk("sr", 8'h80, rd[15:8]);
    chk("rp_n", 8'h01, 8'(rp_n));
    dat = 8'($random(seed));
    exp_b &= dat;
    apb(1, REG_WDATA, 32'(dat));
    go(OP_PROGRAM, 20'h0_1234, 0);
    rdarr(20'h0_1234, exp_b);
    go(OP_READ_STATUS, 0, 0);
    chk("sr", 8'h80, rd[15:8]);
    low <= 1;
    go(OP_PROGRAM, 20'h0_1234, 0);
    chk("sr", 8'h98, rd[15:8]);
    chk("operr", 8'h01, 8'(rd[STAT_OPERR]));
    chk("cmd", CMD_CLEAR, flash.cmd);
    low <= 0;
    apb(1, REG_STAT, 32'h0000_0022);
    rdarr(20'h0_1234, exp_b);
    go(OP_CLEAR, 20'h0_0000, 0);
    chk("cmd", CMD_CLEAR, flash.cmd);
    $display("test program done");
    for (int i = 0; i < 7; i++) begin
      e = tbl[i];
      go(e[10:8], e[31:12], e[11] ? 32'h0000_0020 : 32'h0000_0000);
      chk("sr", e[7:0], rd[15:8]);
      chk("operr", 8'(e[7:0] != 8'h80), 8'(rd[STAT_OPERR]));
      apb(1, REG_STAT, 32'h0000_0022);
    end
    rdarr(20'h1_0005, dat);
    $display("test lock done");
    go(OP_PROGRAM, 20'h0_4000, 32'h0000_0010);
    go(OP_SUSPEND, 20'h0_4000, 0);
    chk("sr", 8'h84, rd[15:8]);
    go(OP_CLEAR, 0, 0);
    chk("refused", 8'h01, 8'(rd[STAT_REFUSED]));
    apb(1, REG_STAT, 32'h0000_0022);
    go(OP_RESUME, 0, 0);
    chk("cmd", CMD_RESUME, flash.cmd);
    go(OP_READ_STATUS, 0, 0);
    chk("sr", 8'h00, rd[15:8]);
    waitr();
    flash.ee = $time + 12000;
    go(OP_SUSPEND, 0, 0);
    chk("esusp", 8'h01, 8'(rd[STAT_ESUSP]));
    go(OP_LOCK_BLOCK, 20'h3_0000, 0);
    chk("refused", 8'h01, 8'(rd[STAT_REFUSED]));
    apb(1, REG_STAT, 32'h0000_0022);
    go(OP_PROGRAM, 20'h3_0000, 32'h0000_0010);
    chk("pend", 8'h01, 8'(rd[STAT_PEND]));
    go(OP_RESUME, 0, 0);
    chk("refused", 8'h01, 8'(rd[STAT_REFUSED]));
    apb(1, REG_STAT, 32'h0000_0022);
    go(OP_READ_STATUS, 0, 0);
    chk("sr", 8'h40, rd[15:8]);
    waitr();
    chk("sr", 8'hC0, rd[15:8]);
    rdarr(20'h3_0000, dat);
    go(OP_RESUME, 0, 0);
    chk("esusp", 8'h00, 8'(rd[STAT_ESUSP]));
    go(OP_READ_STATUS, 0, 0);
    chk("sr", 8'h00, rd[15:8]);
    $display("test suspend done");
    final_report();
  end
endmodule // testbench
